// ---- adcc_ctrl.sv ----
// Control logic of a 10-bit successive-approximation converter
module adcc_ctrl import adcc_pkg::*; (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Power and async clock
  input wire logic stop_i,
  input wire logic async_clk_i,
  // Analog front end
  input wire logic cmp_i,
  output logic [9:0] sar_code_o,
  output logic sample_o,
  output logic [NSEL-1:0] ana_sel_o
);

  // ****************************************
  // Declarations
  // ****************************************
  adcc_clk_cfg_t cfg_r;
  adcc_state_t st_r;
  logic [4:0] chan_r;
  logic coco_r;
  logic [9:0] res_r, sar_nxt;
  logic [3:0] bit_r, samp_r;
  logic [2:0] div_cnt_r;
  logic a_s1_r, a_s2_r, a_s3_r, c_s1_r, c_s2_r;
  logic [NSEL-1:0] sel_nxt;
  logic [2:0] div_lim;
  logic sync_tick, async_edge, halted, conv_tick;
  logic wr_ctrl, wr_clk, rd_low, done_set;
  logic [3:0] samp_lim, last_idx;

  // ****************************************
  // Channel decode
  // ****************************************
  function automatic logic [NSEL-1:0] chan_to_sel(input logic [4:0] ch);
    logic [NSEL-1:0] s;
    s = '0;
    if (ch <= CH_EXT_LAST) begin
      s[ch[1:0]] = 1'b1;
    end
    if (ch == CH_PB0) begin
      s[SEL_PB0] = 1'b1;
    end
    if (ch == CH_PB1) begin
      s[SEL_PB1] = 1'b1;
    end
    if (ch == CH_BANDGAP) begin
      s[SEL_BG] = 1'b1;
    end
    return s;
  endfunction

  assign wr_ctrl = wr_i && (addr_i == OFS_STATUS_CTRL);
  assign wr_clk = wr_i && (addr_i == OFS_CLOCK_CFG);
  assign rd_low = rd_i && (addr_i == OFS_RESULT_LOW);
  assign sel_nxt = chan_to_sel(wdata_i[4:0]);

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_s1_r <= 1'b0;
      a_s2_r <= 1'b0;
      a_s3_r <= 1'b0;
      c_s1_r <= 1'b0;
      c_s2_r <= 1'b0;
    end else begin
      a_s1_r <= async_clk_i;
      a_s2_r <= a_s1_r;
      a_s3_r <= a_s2_r;
      c_s1_r <= cmp_i;
      c_s2_r <= c_s1_r;
    end
  end

  // ****************************************
  // Reference clock selection
  // ****************************************
  // Core clock already runs at four times the bus rate
  assign div_lim = 3'((4'h1 << cfg_r.div) - 4'h1);
  assign sync_tick = (div_cnt_r == div_lim);
  assign async_edge = a_s2_r && !a_s3_r;
  // Without the async clock the reference stops with the core in stop mode
  assign halted = stop_i && !cfg_r.aclk_en;
  assign conv_tick = !halted && (cfg_r.aclk_en ? async_edge : sync_tick);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt_r <= 3'h0;
    end else if (sync_tick || wr_clk) begin
      div_cnt_r <= 3'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_r <= RST_CLK_CFG;
    end else if (wr_clk) begin
      cfg_r.div <= wdata_i[DIV_LSB+:2];
      cfg_r.aclk_en <= wdata_i[ACLK_BIT];
      cfg_r.lsmp <= wdata_i[LSMP_BIT];
      cfg_r.mode10 <= wdata_i[MODE_BIT];
    end
  end

  // Only the analog mux is steered; no digital disable leaves the block
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_r <= RST_CHANNEL;
      ana_sel_o <= '0;
    end else if (wr_ctrl) begin
      chan_r <= wdata_i[4:0];
      ana_sel_o <= sel_nxt;
    end
  end

  // ****************************************
  // Conversion sequence
  // ****************************************
  assign samp_lim = cfg_r.lsmp ? SAMPLE_LONG : SAMPLE_SHORT;
  assign last_idx = cfg_r.mode10 ? LAST_IDX_10 : LAST_IDX_8;
  assign done_set = (st_r == ST_DONE);

  always_comb begin
    sar_nxt = sar_code_o;
    sar_nxt[bit_r] = c_s2_r;
    if (bit_r != last_idx) begin
      sar_nxt[bit_r - 4'h1] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ST_IDLE;
      samp_r <= 4'h0;
      bit_r <= MSB_IDX;
      sar_code_o <= '0;
      sample_o <= 1'b0;
    end else if (wr_ctrl) begin
      // A write to the channel field aborts and, if valid, restarts
      st_r <= (|sel_nxt) ? ST_SAMPLE : ST_IDLE;
      sample_o <= |sel_nxt;
      samp_r <= 4'h0;
      bit_r <= MSB_IDX;
      sar_code_o <= '0;
    end else begin
      case (st_r)
        ST_SAMPLE: begin
          if (conv_tick) begin
            if (samp_r == samp_lim) begin
              st_r <= ST_CONV;
              sample_o <= 1'b0;
              sar_code_o <= SAR_START;
              samp_r <= 4'h0;
            end else begin
              samp_r <= samp_r + 4'h1;
            end
          end
        end
        ST_CONV: begin
          if (samp_r != CMP_SETTLE) begin // Synchronised comparator lags the trial code
            samp_r <= samp_r + 4'h1;
          end else if (conv_tick) begin
            samp_r <= 4'h0;
            sar_code_o <= sar_nxt;
            if (bit_r == last_idx) begin
              st_r <= ST_DONE;
            end else begin
              bit_r <= bit_r - 4'h1;
            end
          end
        end
        ST_DONE: begin
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Result and completion flag
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      res_r <= RST_RESULT;
    end else if (done_set) begin
      res_r <= sar_code_o;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      coco_r <= 1'b0;
    end else if (done_set) begin
      coco_r <= 1'b1;
    end else if (wr_ctrl || rd_low) begin
      coco_r <= 1'b0;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        OFS_STATUS_CTRL: rdata_o <= {coco_r, 2'h0, chan_r};
        OFS_RESULT_HIGH: rdata_o <= cfg_r.mode10 ? {6'h00, res_r[9:8]} : RST_RESULT_HIGH;
        OFS_RESULT_LOW: rdata_o <= cfg_r.mode10 ? res_r[7:0] : res_r[9:2];
        OFS_CLOCK_CFG: rdata_o <= {1'b0, cfg_r, 2'h0};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_start_pb0;
    wr_i && addr_i == OFS_STATUS_CTRL && wdata_i[4:0] == CH_PB0;
  endsequence
  sequence s_start_bg;
    wr_i && addr_i == OFS_STATUS_CTRL && wdata_i[4:0] == CH_BANDGAP;
  endsequence
  sequence s_read_high;
    rd_i && addr_i == OFS_RESULT_HIGH;
  endsequence
  property p_pb0_sel;
    s_start_pb0 |=> ana_sel_o == (7'h01 << SEL_PB0) && st_r == ST_SAMPLE;
  endproperty
  a_pb0_sel: assert property (p_pb0_sel) else $error("port B line zero not selected");
  property p_bg_sel;
    s_start_bg |=> ana_sel_o[SEL_BG] && sample_o;
  endproperty
  a_bg_sel: assert property (p_bg_sel) else $error("bandgap not selected");
  property p_high_10;
    s_read_high ##0 cfg_r.mode10 |=> rdata_o[7:2] == 6'h00 && rdata_o[1:0] == $past(res_r[9:8]);
  endproperty
  a_high_10: assert property (p_high_10) else $error("high register layout wrong");
  property p_high_8;
    s_read_high ##0 !cfg_r.mode10 |=> rdata_o == 8'h00;
  endproperty
  a_high_8: assert property (p_high_8) else $error("high register not zero in 8-bit mode");
  property p_8bit_lsbs;
    st_r == ST_CONV && !cfg_r.mode10 |-> sar_code_o[1:0] == 2'h0;
  endproperty
  a_8bit_lsbs: assert property (p_8bit_lsbs) else $error("8-bit conversion touched low bits");
  property p_async_src;
    conv_tick && cfg_r.aclk_en |-> a_s2_r && !a_s3_r;
  endproperty
  a_async_src: assert property (p_async_src) else $error("tick not from async clock");
  property p_stop_run;
    st_r == ST_CONV && stop_i && cfg_r.aclk_en && async_edge && samp_r == CMP_SETTLE
      && !wr_i |=> st_r == ST_DONE || bit_r != $past(bit_r);
  endproperty
  a_stop_run: assert property (p_stop_run) else $error("conversion stalled in stop mode");
  property p_div2;
    !cfg_r.aclk_en && cfg_r.div == 2'h1 && sync_tick && !$past(wr_i) |-> !$past(sync_tick);
  endproperty
  a_div2: assert property (p_div2) else $error("divider by two ticked twice in a row");
  property p_long;
    st_r == ST_SAMPLE && conv_tick && cfg_r.lsmp && samp_r < SAMPLE_LONG && !wr_i |=> st_r == ST_SAMPLE;
  endproperty
  a_long: assert property (p_long) else $error("long sample ended early");
endmodule

// ---- adcc_pkg.sv ----
// Constants, field layouts and types of the converter control block
package adcc_pkg;

  // ****************************************
  // Register map and reset values
  // ****************************************
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] OFS_STATUS_CTRL = 2'h0;
  localparam logic [1:0] OFS_RESULT_HIGH = 2'h1;
  localparam logic [1:0] OFS_RESULT_LOW = 2'h2;
  localparam logic [1:0] OFS_CLOCK_CFG = 2'h3;
  localparam logic [7:0] RST_RESULT_HIGH = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam logic [4:0] RST_CHANNEL = 5'h1f;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int COCO_BIT = 7;
  localparam int DIV_LSB = 5;
  localparam int ACLK_BIT = 4;
  localparam int LSMP_BIT = 3;
  localparam int MODE_BIT = 2;

  // ****************************************
  // Channel codes and analog selects
  // ****************************************
  localparam logic [4:0] CH_EXT_LAST = 5'h03;
  localparam logic [4:0] CH_PB0 = 5'h04;
  localparam logic [4:0] CH_PB1 = 5'h05;
  localparam logic [4:0] CH_BANDGAP = 5'h1a;
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam int NSEL = 7;
  localparam int SEL_PB0 = 4;
  localparam int SEL_PB1 = 5;
  localparam int SEL_BG = 6;

  // ****************************************
  // Conversion timing, in converter clock ticks; comparator settling (CMP_SETTLE) in core clock cycles
  // ****************************************
  localparam logic [3:0] SAMPLE_SHORT = 4'h3;
  localparam logic [3:0] SAMPLE_LONG = 4'hf;
  localparam logic [3:0] MSB_IDX = 4'h9;
  localparam logic [3:0] LAST_IDX_10 = 4'h0;
  localparam logic [3:0] LAST_IDX_8 = 4'h2;
  localparam logic [9:0] SAR_START = 10'h200;
  localparam logic [3:0] CMP_SETTLE = 4'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV = 2'b11,
    ST_DONE = 2'b10
  } adcc_state_t;

  typedef struct packed {
    logic [1:0] div;
    logic aclk_en;
    logic lsmp;
    logic mode10;
  } adcc_clk_cfg_t;

  localparam adcc_clk_cfg_t RST_CLK_CFG = '{div: 2'h0, aclk_en: 1'b0, lsmp: 1'b0, mode10: 1'b0};

endpackage

// ---- adcc_ana_model.sv ----
// Analog front end model: channel levels and comparator
module adcc_ana_model import adcc_pkg::*; (
  // Clock
  input wire logic core_clk_i,
  // From converter
  input wire logic [9:0] sar_code_i,
  input wire logic [NSEL-1:0] ana_sel_i,
  // Levels and comparator
  input wire logic [NSEL-1:0][9:0] lvl_i,
  output logic cmp_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] vin;
  // ****************************
  // Comparator
  // ****************************
  always_comb begin
    vin = '0;
    for (int i = 0; i < NSEL; i++) begin
      if (ana_sel_i[i]) begin
        vin = lvl_i[i];
      end
    end
  end
  // Pins kept as inputs: no digital driver on the level
  always @(posedge core_clk_i) begin
    if (ana_sel_i == '0) begin
      cmp_o <= (cmp_o !== 1'b1);
    end else begin
      cmp_o <= (vin >= sar_code_i);
    end
  end
endmodule

// ---- tb_top.sv ----
// Testbench of the converter control block
module tb_top import adcc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 0;
  logic rstn_i = 0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [DATA_W-1:0] rdata_o;
  logic wr_i = 0;
  logic rd_i = 0;
  logic stop_i = 0;
  logic async_clk_i = 0;
  logic cmp_i;
  logic sample_o;
  logic rd_d = 0;
  logic [9:0] sar_code_o;
  logic [NSEL-1:0] ana_sel_o;
  logic [NSEL-1:0][9:0] lvl;
  logic [8:0] expq[$];
  logic [8:0] e;
  logic [4:0] chs[7] = '{5'h0, 5'h1, 5'h2, 5'h3, CH_PB0, CH_PB1, CH_BANDGAP};
  int fail_count = 0;
  int checks = 0;
  int slen = 0;
  initial forever #5 core_clk_i = ~core_clk_i;
  // Unrelated to the core clock on purpose
  initial forever #11.5 async_clk_i = ~async_clk_i;
  adcc_ctrl dut_u (.core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .stop_i,
    .async_clk_i, .cmp_i, .sar_code_o, .sample_o, .ana_sel_o);
  adcc_ana_model ana_u (.core_clk_i, .sar_code_i(sar_code_o), .ana_sel_i(ana_sel_o),
    .lvl_i(lvl), .cmp_o(cmp_i));
  // ****************************
  // Tasks
  // ****************************
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [9:0] x, logic [9:0] s);
    checks++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic bus(logic w, logic r, logic [1:0] a, logic [7:0] d);
    @(posedge core_clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
  endtask
  // Bit 8 of a note marks it as compared
  task automatic rd(logic [1:0] a, logic [8:0] x);
    expq.push_back(x);
    bus(0, 1, a, 0);
  endtask
  function automatic logic [6:0] sel_of(logic [4:0] ch);
    if (ch <= CH_EXT_LAST) return 7'h1 << ch;
    if (ch == CH_PB0) return 7'h1 << SEL_PB0;
    if (ch == CH_PB1) return 7'h1 << SEL_PB1;
    if (ch == CH_BANDGAP) return 7'h1 << SEL_BG;
    return 7'h0;
  endfunction
  task automatic poll();
    for (int i = 0; i < 400; i++) begin
      rd(OFS_STATUS_CTRL, 9'h0);
      bus(0, 0, 0, 0);
      #1;
      if (rdata_o[COCO_BIT] === 1'b1) return;
    end
    fail_count++;
    finish_test();
  endtask
  // Sample length only judged on the core clock path
  task automatic conv(logic [4:0] ch, int s, logic [7:0] cfg, int stp);
    logic [9:0] v;
    logic [6:0] sl;
    int dv;
    dv = cfg[6:5];
    v = '0;
    sl = sel_of(ch);
    for (int i = 0; i < NSEL; i++) if (sl[i]) v = lvl[i];
    bus(1, 0, OFS_CLOCK_CFG, cfg);
    bus(1, 0, OFS_STATUS_CTRL, {3'h0, ch});
    bus(0, 0, 0, 0);
    stop_i <= (stp != 0);
    slen = 0;
    #1;
    chk("sel", {3'h0, sel_of(ch)}, {3'h0, ana_sel_o});
    if (stp == 1) begin
      repeat (100) @(posedge core_clk_i);
      rd(OFS_STATUS_CTRL, {4'h1, ch});
      bus(0, 0, 0, 0);
      stop_i <= 1'b0;
    end
    poll();
    stop_i <= 1'b0;
    if (s != 0) chk("slen", 1, (slen <= (s << dv)) && (slen > ((s - 1) << dv)));
    if (cfg[MODE_BIT]) rd(OFS_RESULT_HIGH, {7'h40, v[9:8]});
    else rd(OFS_RESULT_HIGH, 9'h100);
    rd(OFS_RESULT_LOW, {1'b1, cfg[MODE_BIT] ? v[7:0] : v[9:2]});
    rd(OFS_CLOCK_CFG, {1'b1, cfg & 8'h7c});
    rd(OFS_STATUS_CTRL, {4'h1, ch});
    bus(0, 0, 0, 0);
  endtask
  // ****************************
  // Read data monitor
  // ****************************
  always @(posedge core_clk_i) begin
    if (rstn_i && rd_d) begin
      e = expq.pop_front();
      if (e[8]) chk("rdata", {2'h0, e[7:0]}, {2'h0, rdata_o});
    end else if (rstn_i) begin
      chk("idle rdata", 0, {2'h0, rdata_o});
    end
    if (sample_o === 1'b1) slen++;
    rd_d <= rd_i;
  end
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    void'($urandom(32'h7dc510bb));
    for (int i = 0; i < NSEL; i++) lvl[i] = 10'($urandom);
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(OFS_STATUS_CTRL, {4'h1, RST_CHANNEL});
    rd(OFS_RESULT_HIGH, {1'b1, RST_RESULT_HIGH});
    rd(OFS_RESULT_LOW, 9'h100);
    rd(OFS_CLOCK_CFG, 9'h100);
    bus(1, 0, OFS_RESULT_HIGH, 8'hff);
    rd(OFS_RESULT_HIGH, 9'h100);
    for (int i = 0; i < 7; i++) conv(chs[i], SAMPLE_SHORT + 1, {5'h0, i[0], 2'h0}, 0);
    conv(CH_PB0, SAMPLE_LONG + 1, 8'h0c, 0);
    conv(CH_PB1, SAMPLE_SHORT + 1, 8'h64, 0);
    conv(5'h2, 0, 8'h04, 1);
    conv(CH_BANDGAP, 0, 8'h14, 2);
    bus(1, 0, OFS_STATUS_CTRL, {3'h0, CH_OFF});
    bus(0, 0, 0, 0);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("sel off", 0, {3'h0, ana_sel_o});
    repeat (4) @(posedge core_clk_i);
    finish_test();
  end
endmodule
